// ---- core/nsx_exec.sv ----
// Execution datapath for nibble swap, XOR and direction load operations.
// Notes on behaviour
// - Swap result: low nibble up, high down.
// - Swap to accumulator or file; flags kept.
// - Literal XOR into accumulator, zero flag only.
// - File XOR with 7-bit address, zero flag.
// - File XOR destination selected by dest bit.
// - Direction load: 5 A, 6 B, 7 C.
`timescale 1ns/1ps
module nsx_exec (
  input  wire logic                     clk_i,
  input  wire logic                     rst_b_i,
  input  wire nsx_pkg::nsx_req_type     req_i,
  input  wire logic                     req_valid_i,
  output logic [7:0]                    acc_o,
  output logic                          zero_o,
  output nsx_pkg::nsx_file_wr_type      file_wr_o,
  output nsx_pkg::nsx_dir_type          dir_o
);
  import nsx_pkg::*;

  // Accumulator and zero flag group.
  logic [7:0]      acc_ff;
  logic [7:0]      nxt_acc;
  logic            zero_ff;
  logic            nxt_zero;

  // File register write-back group.
  nsx_file_wr_type file_wr_ff;
  nsx_file_wr_type nxt_file_wr;

  // Port direction register group.
  nsx_dir_type     dir_ff;
  nsx_dir_type     nxt_dir;

  // Shared decode of the incoming request.
  logic            take_swap;
  logic            take_xor_lit;
  logic            take_xor_file;
  logic            take_dir;
  logic            dest_is_file;

  // Results of the three arithmetic paths.
  logic [7:0]      swap_result;
  logic [7:0]      xor_lit_result;
  logic [7:0]      xor_file_result;

  // Nibble exchange of a file operand.
  function automatic logic [7:0] swap_nibbles(input logic [7:0] val);
    swap_nibbles = {val[NIB_LO_MSB:NIB_LO_LSB], val[NIB_HI_MSB:NIB_HI_LSB]};
  endfunction

  // A request only counts when it is valid and carries the wanted code.
  function automatic logic is_op(input logic       valid,
                                 input nsx_op_type op,
                                 input nsx_op_type want);
    is_op = valid && (op == want);
  endfunction

  // The zero flag follows the full eight-bit result.
  function automatic logic is_zero(input logic [7:0] val);
    is_zero = (val == 8'h00);
  endfunction

  // Match of a load operand against one direction register selector.
  function automatic logic dir_hit(input logic [6:0] addr,
                                   input logic [6:0] sel);
    dir_hit = (addr == sel);
  endfunction

  // Operation decode is shared by all three state groups.
  assign take_swap     = is_op(req_valid_i, req_i.op, NSX_OP_NIBBLE_SWAP);
  assign take_xor_lit  = is_op(req_valid_i, req_i.op, NSX_OP_XOR_LITERAL);
  assign take_xor_file = is_op(req_valid_i, req_i.op, NSX_OP_XOR_FILE);
  assign take_dir      = is_op(req_valid_i, req_i.op, NSX_OP_LOAD_DIRECTION);
  assign dest_is_file  = (req_i.dest == DEST_FILE);

  // Both XOR paths read the accumulator as it stands at the request edge,
  // so back-to-back operations see the previous result without a bypass.
  assign swap_result     = swap_nibbles(req_i.file_data);
  assign xor_lit_result  = acc_ff ^ req_i.literal;
  assign xor_file_result = acc_ff ^ req_i.file_data;

  // Accumulator and zero flag next values.
  always_comb begin
    nxt_acc  = acc_ff;
    nxt_zero = zero_ff;

    // The swap never touches the zero flag.
    if (take_swap && !dest_is_file) begin
      nxt_acc = swap_result;
    end

    if (take_xor_lit) begin
      nxt_acc  = xor_lit_result;
      nxt_zero = is_zero(xor_lit_result);
    end

    if (take_xor_file) begin
      nxt_zero = is_zero(xor_file_result);
      if (!dest_is_file) begin
        nxt_acc = xor_file_result;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_ff  <= ACC_RST;
      zero_ff <= ZERO_RST;
    end else begin
      acc_ff  <= nxt_acc;
      zero_ff <= nxt_zero;
    end
  end

  // Write-back next value.
  // The address simply follows the request when no write is due, which
  // saves a mux; the memory must look at the strobe only.
  always_comb begin
    nxt_file_wr = '{we: 1'b0, addr: req_i.addr, data: 8'h00};

    if (take_swap && dest_is_file) begin
      nxt_file_wr.we   = 1'b1;
      nxt_file_wr.data = swap_result;
    end

    if (take_xor_file && dest_is_file) begin
      nxt_file_wr.we   = 1'b1;
      nxt_file_wr.data = xor_file_result;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      file_wr_ff <= '{we: 1'b0, addr: 7'h00, data: 8'h00};
    end else begin
      file_wr_ff <= nxt_file_wr;
    end
  end

  // Direction register next values.
  // Operands outside 5..7 select no direction register and are ignored,
  // so a stray code cannot flip a pin between input and output.
  always_comb begin
    nxt_dir = dir_ff;

    if (take_dir) begin
      if (dir_hit(req_i.addr, DIR_A_SEL)) begin
        nxt_dir.port_a = acc_ff;
      end

      if (dir_hit(req_i.addr, DIR_B_SEL)) begin
        nxt_dir.port_b = acc_ff;
      end

      if (dir_hit(req_i.addr, DIR_C_SEL)) begin
        nxt_dir.port_c = acc_ff;
      end
    end
  end

  // All ports come out of reset as inputs, so nothing is driven before
  // software has chosen a direction.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dir_ff <= '{port_a: DIR_RST, port_b: DIR_RST, port_c: DIR_RST};
    end else begin
      dir_ff <= nxt_dir;
    end
  end

  // Every output is a register, so nothing combinational reaches the pins.
  assign acc_o     = acc_ff;
  assign zero_o    = zero_ff;
  assign file_wr_o = file_wr_ff;
  assign dir_o     = dir_ff;

  // Notes for integration.
  // The decoder supplies the current file value with each request; this
  // block keeps no copy of data memory.
  // A write-back strobe stands for exactly one cycle after its request.
  // Back-to-back requests are taken on every edge with no wait state.
  // Requests with no operation code leave the accumulator, zero flag and direction registers as they are; the write-back strobe clears.
  // The accumulator is held when an XOR result goes back to the file.
  // The zero flag changes only on the two XOR operations.
  // The direction registers change only on a valid load operation.
endmodule

// ---- core/nsx_pkg.sv ----
// Package with constants and carrier types for the nibble swap / XOR / direction datapath.
package nsx_pkg;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned ADDR_W     = 7;
  localparam logic [7:0]  ACC_RST    = 8'h00;
  localparam logic [7:0]  DIR_RST    = 8'hFF;
  localparam logic        ZERO_RST   = 1'b0;
  localparam logic [6:0]  DIR_A_SEL  = 7'h05;
  localparam logic [6:0]  DIR_B_SEL  = 7'h06;
  localparam logic [6:0]  DIR_C_SEL  = 7'h07;
  localparam logic        DEST_ACC   = 1'b0;
  localparam logic        DEST_FILE  = 1'b1;
  localparam int unsigned NIB_HI_MSB = 7;
  localparam int unsigned NIB_HI_LSB = 4;
  localparam int unsigned NIB_LO_MSB = 3;
  localparam int unsigned NIB_LO_LSB = 0;

  typedef enum logic [2:0] {
    NSX_OP_NONE,
    NSX_OP_NIBBLE_SWAP,
    NSX_OP_XOR_LITERAL,
    NSX_OP_XOR_FILE,
    NSX_OP_LOAD_DIRECTION
  } nsx_op_type;

  typedef struct packed {
    nsx_op_type  op;
    logic [6:0]  addr;
    logic        dest;
    logic [7:0]  literal;
    logic [7:0]  file_data;
  } nsx_req_type;

  typedef struct packed {
    logic        we;
    logic [6:0]  addr;
    logic [7:0]  data;
  } nsx_file_wr_type;

  typedef struct packed {
    logic [7:0]  port_a;
    logic [7:0]  port_b;
    logic [7:0]  port_c;
  } nsx_dir_type;
endpackage

// ---- tb/nsx_exec_sva.sv ----
// Checker that watches the datapath ports.
`timescale 1ns/1ps
module nsx_exec_sva (input wire logic clk_i, input wire logic rst_b_i,
  input wire nsx_pkg::nsx_req_type req_i, input wire logic req_valid_i,
  input wire logic [7:0] acc_o, input wire logic zero_o,
  input wire nsx_pkg::nsx_file_wr_type file_wr_o, input wire nsx_pkg::nsx_dir_type dir_o);
  import nsx_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  chk_swap_acc: assert property (req_valid_i && req_i.op == NSX_OP_NIBBLE_SWAP
    && !req_i.dest |=> acc_o == {$past(req_i.file_data[3:0]), $past(req_i.file_data[7:4])})
    else $error("swap result wrong");
  chk_xor_lit: assert property (req_valid_i && req_i.op == NSX_OP_XOR_LITERAL
    |=> acc_o == ($past(acc_o) ^ $past(req_i.literal)) && zero_o == (acc_o == 8'h00))
    else $error("literal xor wrong");
  chk_xor_file: assert property (req_valid_i && req_i.op == NSX_OP_XOR_FILE && req_i.dest
    |=> file_wr_o.we && file_wr_o.data == ($past(acc_o) ^ $past(req_i.file_data)))
    else $error("file xor write wrong");
  chk_flags_kept: assert property (req_valid_i && req_i.op == NSX_OP_NIBBLE_SWAP
    |=> $stable(zero_o)) else $error("swap touched zero");
  chk_dir_b: assert property (req_valid_i && req_i.op == NSX_OP_LOAD_DIRECTION
    && req_i.addr == DIR_B_SEL |=> dir_o.port_b == $past(acc_o) && $stable(zero_o))
    else $error("direction load wrong");
  chk_swap_file: assert property (req_valid_i && req_i.op == NSX_OP_NIBBLE_SWAP && req_i.dest
    |=> file_wr_o.we && file_wr_o.data == {$past(req_i.file_data[3:0]), $past(req_i.file_data[7:4])}
    && $stable(acc_o)) else $error("swap write-back wrong");
  chk_xor_file_acc: assert property (req_valid_i && req_i.op == NSX_OP_XOR_FILE && !req_i.dest
    |=> acc_o == ($past(acc_o) ^ $past(req_i.file_data)) && zero_o == (acc_o == 8'h00)
    && !file_wr_o.we) else $error("file xor into accumulator wrong");
endmodule
bind nsx_exec nsx_exec_sva u_sva (.*);

// ---- tb/nsx_mem.sv ----
// Data memory model that serves file operands and takes write-backs.
`timescale 1ns/1ps
module nsx_mem (input wire logic clk_i, input wire logic [6:0] addr_i,
  input wire nsx_pkg::nsx_file_wr_type wr_i, output logic [7:0] data_o);
  logic [7:0] m [128] = '{default: 8'h3C};
  assign data_o = m[addr_i];
  always @(posedge clk_i) if (wr_i.we) m[wr_i.addr] <= wr_i.data;
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the datapath.
`timescale 1ns/1ps
module tb;
  import nsx_pkg::*;
  logic clk_i = 0, rst_b_i = 0, v = 0, z;
  logic [7:0] a, fd;
  nsx_req_type q = '0;
  nsx_file_wr_type w;
  nsx_dir_type d;
  int n_errors = 0, check_count = 0;
  always #12.5 clk_i = ~clk_i;
  nsx_mem mem (.clk_i(clk_i), .addr_i(q.addr), .wr_i(w), .data_o(fd));
  nsx_exec dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i({q[26:8], fd}), .req_valid_i(v),
    .acc_o(a), .zero_o(z), .file_wr_o(w), .dir_o(d));
  task ck(string n, logic [7:0] e, g);
    check_count++;
    if (g !== e) $display("MISMATCH %s expected %h seen %h", n, e, g);
    if (g !== e) n_errors++;
  endtask
  // Results land one cycle after the request edge, so checks sit at the next falling edge.
  task op(nsx_op_type o, logic [6:0] ad, logic ds, logic [7:0] l, ea, logic ez, logic [7:0] ew);
    @(negedge clk_i) {q, v} = {o, ad, ds, l, 8'h00, 1'b1};
    @(negedge clk_i) v = 0;
    ck("acc", ea, a);
    ck("zero", 8'(ez), z);
    ck("file we", 8'(ds), 8'(w.we));
    if (ds) ck("file data", ew, w.data);
    if (ds) ck("file addr", 8'(ad), 8'(w.addr));
  endtask
  task t_ops;
    op(NSX_OP_NIBBLE_SWAP, 7'h09, 1'b1, 8'h00, 8'h00, 1'b0, 8'hC3);
    op(NSX_OP_NIBBLE_SWAP, 7'h09, 1'b0, 8'h00, 8'h3C, 1'b0, 8'h00);
    op(NSX_OP_XOR_LITERAL, 7'h00, 1'b0, 8'h3C, 8'h00, 1'b1, 8'h00);
    op(NSX_OP_XOR_LITERAL, 7'h00, 1'b0, 8'hA5, 8'hA5, 1'b0, 8'h00);
    op(NSX_OP_XOR_FILE, 7'h7F, 1'b1, 8'h00, 8'hA5, 1'b0, 8'h99);
    op(NSX_OP_XOR_FILE, 7'h02, 1'b0, 8'h00, 8'h99, 1'b0, 8'h00);
    op(NSX_OP_XOR_FILE, 7'h7F, 1'b0, 8'h00, 8'h00, 1'b1, 8'h00);
  endtask
  task t_dir;
    op(NSX_OP_LOAD_DIRECTION, 7'h06, 1'b0, 8'h00, 8'h00, 1'b1, 8'h00);
    ck("port b", 8'h00, d.port_b);
    ck("port a", DIR_RST, d.port_a);
    op(NSX_OP_XOR_LITERAL, 7'h00, 1'b0, 8'h5A, 8'h5A, 1'b0, 8'h00);
    op(NSX_OP_LOAD_DIRECTION, 7'h07, 1'b0, 8'h00, 8'h5A, 1'b0, 8'h00);
    ck("port c", 8'h5A, d.port_c);
    op(NSX_OP_LOAD_DIRECTION, 7'h04, 1'b0, 8'h00, 8'h5A, 1'b0, 8'h00);
    ck("port a kept", DIR_RST, d.port_a);
    ck("port b kept", 8'h00, d.port_b);
    op(NSX_OP_LOAD_DIRECTION, 7'h05, 1'b0, 8'h00, 8'h5A, 1'b0, 8'h00);
    ck("port a", 8'h5A, d.port_a);
    ck("port c kept", 8'h5A, d.port_c);
  endtask
  task results;
    $display("mismatches %0d comparisons %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #250 rst_b_i = 1;
    t_ops;
    t_dir;
    results;
  end
endmodule
